// file: include/ccr_regs.svh
/*
 * register offsets, field positions, reset values and timing counts
 * for the chopping and amplifier configuration block.
 * assumes a 20 MHz mclk and an apb register bus with 32-bit data.
 */
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CCR_CFG_INDEX 12'h005
`define CCR_CFG_ADDR 12'h014
`define CCR_STAT_ADDR 12'h018
`define CCR_CFG_RESET 8'h01

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCR_OFF_HI 7
`define CCR_OFF_LO 6
`define CCR_REGDIS_BIT 5
`define CCR_SCALE_HI 4
`define CCR_SCALE_LO 3
`define CCR_HOLD_BIT 2
`define CCR_GAIN_HI 1
`define CCR_GAIN_LO 0

// ----------------------------------------
// timing
// ----------------------------------------
`define CCR_CLK_MHZ 20
`define CCR_OFF_US_0 25
`define CCR_OFF_US_1 50
`define CCR_OFF_US_2 100
`define CCR_OFF_US_3 200
`define CCR_BLANK_US 2
`define CCR_OFF_CYC(us) ((us) * `CCR_CLK_MHZ)
`define CCR_BLANK_CYC (`CCR_BLANK_US * `CCR_CLK_MHZ)

`endif

// file: include/ccr_pkg.sv
/*
 * types for the chopping and amplifier configuration block.
 * assumes ccr_regs.svh for numbers.
 */
package ccr_pkg;

    // ----------------------------------------
    // decoded configuration
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] off_period_select;
        logic regulation_disable;
        logic [1:0] ref_scale;
        logic hold_amp_enable;
        logic [1:0] amp_gain;
    } ccr_cfg_t;

    typedef enum logic [1:0] {CCR_IDLE, CCR_DRIVE, CCR_BLANK, CCR_OFF} ccr_state_t;

endpackage

// file: core/ccr_chop_config.sv
/*
 * chopping and amplifier configuration register with its off-time timer.
 * assumes an apb master on mclk and a current comparator input that is
 * synchronous to mclk.
 * a trip seen during blanking or off time is dropped, not remembered, so
 * the comparator must hold its level while the current stays high.
 */
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "ccr_regs.svh"

module ccr_chop_config
(
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bridge control
    input wire logic drive_request,
    input wire logic current_trip,
    // analog settings
    output ccr_pkg::ccr_cfg_t cfg,
    output logic chop_off,
    output logic bridge_on
);
    import ccr_pkg::*;

    // ----------------------------------------
    // register access
    // ----------------------------------------
    logic [7:0] cfg_reg;
    ccr_state_t state;
    ccr_state_t next_state;
    logic [12:0] count;
    logic [12:0] next_count;
    // setup phase is the cycle with psel high and penable low
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire hit_cfg = (paddr == `CCR_CFG_ADDR);
    wire hit_stat = (paddr == `CCR_STAT_ADDR);
    wire hit_any = hit_cfg | hit_stat;
    // the access phase always sees pready high, so the write lands on it
    wire do_write = access & pwrite & hit_cfg;
    wire [31:0] cfg_word = {24'h000000, cfg_reg};
    wire [31:0] stat_word = {30'h0, state};
    wire [31:0] rd_mux = hit_cfg ? cfg_word :
                         hit_stat ? stat_word : 32'h00000000;
    // read data only launched for reads, so writes never show stale data
    wire [31:0] next_prdata = (setup & ~pwrite) ? rd_mux : 32'h00000000;
    wire next_pready = setup;
    // unmapped offsets answer with an error; the status word is read-only
    // and a write to it is simply dropped
    wire next_pslverr = setup & ~hit_any;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_reg <= `CCR_CFG_RESET;
        end
        else if (do_write)
        begin
            cfg_reg <= pwdata[7:0];
        end
    end

    // single-cycle access: ready goes high in the access phase
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------
    // field decode
    // ----------------------------------------
    wire [1:0] off_sel = cfg_reg[`CCR_OFF_HI:`CCR_OFF_LO];
    wire reg_dis = cfg_reg[`CCR_REGDIS_BIT];
    wire [12:0] off_cyc_0 = 13'(`CCR_OFF_CYC(`CCR_OFF_US_0));
    wire [12:0] off_cyc_1 = 13'(`CCR_OFF_CYC(`CCR_OFF_US_1));
    wire [12:0] off_cyc_2 = 13'(`CCR_OFF_CYC(`CCR_OFF_US_2));
    wire [12:0] off_cyc_3 = 13'(`CCR_OFF_CYC(`CCR_OFF_US_3));
    wire [12:0] off_cycles = (off_sel == 2'h0) ? off_cyc_0 :
                             (off_sel == 2'h1) ? off_cyc_1 :
                             (off_sel == 2'h2) ? off_cyc_2 : off_cyc_3;
    wire [12:0] blank_cycles = 13'(`CCR_BLANK_CYC);
    // a count of one or less ends a timed phase on this edge
    wire count_done = (count <= 13'h0001);
    // never wraps: a phase ends and reloads before the count reaches zero
    wire [12:0] count_less = count - 13'h0001;

    // registered copy, so the analog side never sees a decode glitch
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg <= ccr_cfg_t'(`CCR_CFG_RESET);
        end
        else
        begin
            cfg <= ccr_cfg_t'(cfg_reg);
        end
    end

    // ----------------------------------------
    // fixed off-time chopper
    // ----------------------------------------
    // trips are ignored during blanking, so each chop period is at least
    // blank plus off time long
    always_comb
    begin
        next_state = state;
        next_count = count;
        case (state)
            CCR_IDLE:
            begin
                if (drive_request)
                begin
                    next_state = CCR_BLANK;
                    next_count = blank_cycles;
                end
            end
            CCR_BLANK:
            begin
                if (!drive_request)
                begin
                    next_state = CCR_IDLE;
                end
                else if (count_done)
                begin
                    next_state = CCR_DRIVE;
                end
                else
                begin
                    next_count = count_less;
                end
            end
            CCR_DRIVE:
            begin
                if (!drive_request)
                begin
                    next_state = CCR_IDLE;
                end
                else if (current_trip && !reg_dis)
                begin
                    next_state = CCR_OFF;
                    next_count = off_cycles;
                end
            end
            CCR_OFF:
            begin
                if (!drive_request)
                begin
                    next_state = CCR_IDLE;
                end
                else if (count_done)
                begin
                    next_state = CCR_BLANK;
                    next_count = blank_cycles;
                end
                else
                begin
                    next_count = count_less;
                end
            end
            default:
            begin
                next_state = CCR_IDLE;
            end
        endcase
    end

    // outputs follow the next state so they line up with the state register
    wire next_chop_off = (next_state == CCR_OFF);
    wire next_bridge_on = (next_state == CCR_BLANK) || (next_state == CCR_DRIVE);

    // state and phase counter
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= CCR_IDLE;
            count <= 13'h0000;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
        end
    end

    // bridge outputs straight from flops, off time excludes drive
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chop_off <= 1'b0;
            bridge_on <= 1'b0;
        end
        else
        begin
            chop_off <= next_chop_off;
            bridge_on <= next_bridge_on;
        end
    end

endmodule

// file: tb/ccr_chop_config_chk.sv
/* assertions on the config block ports; bound into its top module */
`timescale 1ns/1ps
`include "ccr_regs.svh"
module ccr_chop_config_chk
(
    input wire logic mclk, arst_n, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic pready, pslverr, drive_request, current_trip, chop_off, bridge_on,
    input wire ccr_pkg::ccr_cfg_t cfg
);
logic [12:0] n;
wire acc = psel && penable;
default clocking @(posedge mclk); endclocking
default disable iff (!arst_n);
always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n) n <= 13'h0;
    else n <= chop_off ? n + 13'h1 : 13'h0;
chk_ready_zero: assert property (psel && !penable |=> pready)
    else $error("pready late");
chk_write_cfg: assert property (acc && pwrite && paddr == `CCR_CFG_ADDR
    |-> ##2 cfg == $past(pwdata[7:0], 2)) else $error("cfg not written");
chk_reset_cfg: assert property ($rose(arst_n) |-> cfg == `CCR_CFG_RESET)
    else $error("bad reset value");
chk_unmapped_err: assert property (acc && pready && paddr != `CCR_CFG_ADDR
    && paddr != `CCR_STAT_ADDR |-> pslverr && prdata == 32'h0) else $error("no error");
chk_off_time: assert property ($fell(chop_off) && bridge_on
    |-> n == (13'h1f4 << cfg.off_period_select)) else $error("off time wrong");
chk_reg_disable: assert property (!chop_off ##1 cfg.regulation_disable |-> !chop_off)
    else $error("chop while disabled");
chk_off_excl: assert property (chop_off |-> !bridge_on)
    else $error("drive in off time");
cover property ($rose(chop_off));
cover property (pslverr);
cover property (cfg.regulation_disable && current_trip);
endmodule
bind ccr_chop_config ccr_chop_config_chk u_chk (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive_request(drive_request),
    .current_trip(current_trip), .chop_off(chop_off), .bridge_on(bridge_on), .cfg(cfg));

// file: tb/ccr_chop_config_tb.sv
/* register and chopper sequences; assumes the block at 20 MHz */
`timescale 1ns/1ps
`include "ccr_regs.svh"
module ccr_chop_config_tb;
import ccr_pkg::*;
logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
logic drive_request = 0, current_trip = 0, pready, pslverr, e, chop_off, bridge_on;
logic [11:0] paddr = 12'h0;
logic [31:0] pwdata = 32'h0, prdata, r;
logic [7:0] v;
ccr_cfg_t cfg;
int err_count = 0, checked = 0, cyc = 0, n;
always #25 mclk = ~mclk;
ccr_chop_config DUT (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .drive_request, .current_trip, .cfg, .chop_off, .bridge_on);
task final_report;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
always @(posedge mclk) if (++cyc > 20000)
begin
    err_count++;
    final_report;
end
task check(input logic [31:0] s, x);
    checked++;
    if (s !== x)
    begin
        err_count++;
        $display("MISMATCH %0t got %h exp %h", $time, s, x);
    end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
endtask
initial
begin
    repeat (6) @(posedge mclk);
    arst_n <= 1;
    apb(0, `CCR_CFG_ADDR, 0); check(r, 32'h01);
    for (int i = 0; i < 4; i++)
    begin
        v = {i[1:0], i[0], i[1:0], i[1], i[1:0]};
        apb(1, `CCR_CFG_ADDR, {24'h0, v});
        apb(0, `CCR_CFG_ADDR, 0); check(r, {24'h0, v});
        check(32'(cfg), {24'h0, v});
    end
    apb(1, `CCR_STAT_ADDR, 32'h3);
    apb(0, `CCR_STAT_ADDR, 0); check(r, 32'h0);
    apb(0, 12'h020, 0); check(e, 1); check(r, 0);
    for (int s = 0; s < 4; s++)
    begin
        apb(1, `CCR_CFG_ADDR, {24'h0, s[1:0], 6'h01});
        drive_request <= 1;
        repeat (60) @(posedge mclk);
        current_trip <= 1;
        @(posedge mclk) current_trip <= 0;
        while (!chop_off) @(negedge mclk);
        n = 0;
        while (chop_off)
        begin
            n++;
            @(negedge mclk);
        end
        check(n, 500 << s);
        check(bridge_on, 1);
        @(posedge mclk) current_trip <= 1;
        n = 0;
        while (!chop_off)
        begin
            n++;
            @(negedge mclk);
        end
        check(n, `CCR_BLANK_CYC + 1);
        @(posedge mclk) drive_request <= 0;
        current_trip <= 0;
    end
    apb(1, `CCR_CFG_ADDR, 32'h21);
    drive_request <= 1;
    repeat (60) @(posedge mclk);
    current_trip <= 1;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    check(chop_off, 0);
    check(bridge_on, 1);
    apb(0, `CCR_STAT_ADDR, 0); check(r, 32'h1);
    current_trip <= 0;
    drive_request <= 0;
    final_report;
end
endmodule
